// >>> hw/gate_drv_ctrl.sv
// control and fault management of the four-channel gate driver
// How it works
// - gate drives on while its effective command is high, off while low.
// - effective command is discrete input OR the written gate bit.
// - drain/source comparator results decide short faults per channel.
// - reset pin low clears all latched channel faults.
// - reset pin low returns input and fault registers to defaults.
// - reset pin held low past the hold time enters sleep.
// - output enable low forces every gate output off.
// - fault pin asserts low while any system or load fault exists.
// - power-up reset loads the fault register with zeros.
// - sleep turns off pump and regulator and blocks writes and fault-byte reads.
// - entering sleep clears input and fault registers.
// - system faults are never stored in channel fault registers.
// - system flags stay latched until the fault byte is read or the reset pin goes low.
// - load faults latch per channel into fault bits 2..0 on report.
// - masking and clearing act only on the selected channel.
// - command bits 7..6 select channel 1 to 4 as 00 to 11.
// - clear bit clears that channel's latch; gate follows again.
// - short to ground after blank latches, gates off, flags fault.
// - pump undervoltage disables all outputs; thermal only flags.
`default_nettype none
module gate_drv_ctrl #(
	parameter int SLEEP_CYCLES = gate_drv_pkg::SLEEP_CYC,
	parameter int SLEEP_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	input wire logic [3:0] gate_command_input,
	input wire logic [3:0] drain_sense_input,
	input wire logic [3:0] source_sense_input,
	input wire logic [3:0] open_load_sense,
	input wire logic output_enable,
	input wire logic reset_sleep_n,
	input wire logic regulator_uv,
	input wire logic pump_uv,
	input wire logic logic_uv,
	input wire logic thermal_warn,
	output logic [3:0] gate_drive_output,
	input wire logic fault_flag_n_i,
	output logic fault_flag_n_o,
	output logic fault_flag_n_oe,
	output logic pump_en,
	output logic regulator_en,
	output logic sleep_mode
);
	localparam int N = gate_drv_pkg::NUM_CH;
	localparam logic [SLEEP_W-1:0] SLEEP_LIM = SLEEP_W'(SLEEP_CYCLES);

	// ==========================================================
	// next reporting channel after the last one, ascending with wrap
	function automatic logic [2:0] next_fault(input logic [3:0] has,
		input logic [1:0] last);
		logic [1:0] c;
		next_fault = 3'h0;
		for (int k = 4; k >= 1; k--) begin
			c = last + 2'(k);
			if (has[c]) begin
				next_fault = {1'b1, c};
			end
		end
	endfunction

	// ==========================================================
	// sleep timing
	logic [SLEEP_W-1:0] low_cnt_q, low_cnt_d;
	logic sleep_q, sleep_d;

	always_comb begin
		if (reset_sleep_n) begin
			low_cnt_d = '0;
		end else if (low_cnt_q != SLEEP_LIM) begin
			low_cnt_d = low_cnt_q + 1'b1;
		end else begin
			low_cnt_d = low_cnt_q;
		end
		sleep_d = !reset_sleep_n && (low_cnt_q == SLEEP_LIM);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			low_cnt_q <= '0;
			sleep_q <= 1'b0;
		end else begin
			low_cnt_q <= low_cnt_d;
			sleep_q <= sleep_d;
		end
	end

	// ==========================================================
	// command register and per-channel configuration
	logic [7:0] input_q, input_d;
	gate_drv_pkg::ch_cfg_t [N-1:0] cfg_q, cfg_d;
	logic [N-1:0] clr_cmd;
	logic cmd_wr, fault_rd;
	logic [1:0] wch;

	always_comb begin
		// writes and fault-byte reads are dead while asleep or while the reset pin is low
		cmd_wr = wr_en && (addr == gate_drv_pkg::CMD_ADDR) && !sleep_q &&
			reset_sleep_n;
		fault_rd = rd_en && (addr == gate_drv_pkg::FAULT_ADDR) &&
			!sleep_q && reset_sleep_n;
		wch = wdata[gate_drv_pkg::CMD_CH_LSB +: 2];
		input_d = input_q;
		cfg_d = cfg_q;
		clr_cmd = '0;
		if (!reset_sleep_n) begin
			input_d = gate_drv_pkg::CMD_RESET;
			cfg_d = '0;
		end else if (cmd_wr) begin
			input_d = wdata;
			if (wdata[gate_drv_pkg::CMD_RDEN_BIT]) begin
				cfg_d[wch].gate = wdata[gate_drv_pkg::CMD_GATE_BIT];
				cfg_d[wch].blank = wdata[gate_drv_pkg::CMD_BLANK_LSB +: 2];
				cfg_d[wch].mask = wdata[gate_drv_pkg::CMD_MASK_BIT];
				clr_cmd[wch] = wdata[gate_drv_pkg::CMD_CLEAR_BIT];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			input_q <= gate_drv_pkg::CMD_RESET;
			cfg_q <= '0;
		end else begin
			input_q <= input_d;
			cfg_q <= cfg_d;
		end
	end

	// ==========================================================
	// channels
	gate_drv_pkg::load_flt_t [N-1:0] flt;
	logic [N-1:0] gate;
	logic drive_ok;

	// pump or supply undervoltage drops every output
	assign drive_ok = output_enable && !pump_uv && !logic_uv &&
		!regulator_uv && !sleep_q;

	for (genvar i = 0; i < N; i++) begin : g_ch
		gate_channel u_ch (
			.clk(clk),
			.rst(rst),
			.cmd_on(gate_command_input[i] | cfg_q[i].gate),
			.drive_ok(drive_ok),
			.clear(clr_cmd[i] || !reset_sleep_n),
			.sleep(sleep_q),
			.sense({drain_sense_input[i], source_sense_input[i],
				open_load_sense[i]}),
			.cfg(cfg_q[i]),
			.gate_q(gate[i]),
			.flt_q(flt[i])
		);
	end

	// ==========================================================
	// system flags, fault byte and reporting order
	gate_drv_pkg::sys_flt_t sys_q, sys_d, sys_raw;
	logic [1:0] poll_q, poll_d;
	logic [3:0] has;
	logic [2:0] pick;
	logic [7:0] fault_byte;

	always_comb begin
		sys_raw.supply_uv = regulator_uv || logic_uv;
		sys_raw.pump_uv = pump_uv;
		sys_raw.thermal = thermal_warn;
		for (int i = 0; i < N; i++) begin
			has[i] = |flt[i];
		end
		pick = next_fault(has, poll_q);
		if (pick[2]) begin
			fault_byte = {pick[1:0], sys_q, flt[pick[1:0]]};
		end else begin
			fault_byte = {2'b00, sys_q, 3'b000};
		end
		// a still-present cause sets again over the clear
		if (sleep_d) begin
			sys_d = gate_drv_pkg::SYS_RESET;
		end else if (fault_rd || !reset_sleep_n) begin
			sys_d = sys_raw;
		end else begin
			sys_d = sys_q | sys_raw;
		end
		poll_d = (fault_rd && pick[2]) ? pick[1:0] : poll_q;
		if (!reset_sleep_n) begin
			poll_d = 2'h3;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sys_q <= gate_drv_pkg::SYS_RESET;
			poll_q <= 2'h3;
		end else begin
			sys_q <= sys_d;
			poll_q <= poll_d;
		end
	end

	// ==========================================================
	// read port and pins
	logic [7:0] rdata_d;
	logic any_fault;

	always_comb begin
		rdata_d = 8'h00;
		if (rd_en) begin
			if (addr == gate_drv_pkg::CMD_ADDR) begin
				rdata_d = input_q;
			end else if (addr == gate_drv_pkg::FAULT_ADDR) begin
				rdata_d = fault_rd ? fault_byte : 8'h00;
			end else if (addr == gate_drv_pkg::STAT_ADDR) begin
				rdata_d = {fault_flag_n_i, sleep_q, 2'b00, gate};
			end
		end
		any_fault = (|sys_q) || (|sys_raw) || (|has);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 8'h00;
			fault_flag_n_o <= 1'b0;
			fault_flag_n_oe <= 1'b0;
			pump_en <= 1'b0;
			regulator_en <= 1'b0;
			sleep_mode <= 1'b0;
		end else begin
			rdata <= rdata_d;
			fault_flag_n_o <= 1'b0;
			fault_flag_n_oe <= any_fault && !sleep_d;
			pump_en <= !sleep_d;
			regulator_en <= !sleep_d;
			sleep_mode <= sleep_d;
		end
	end

	assign gate_drive_output = gate;

	// ==========================================================
	// checks
	property p_gate_follow;
		@(posedge clk) disable iff (rst)
		(gate_command_input[0] && drive_ok && flt[0] == '0)
			|=> gate_drive_output[0];
	endproperty
	a_gate_follow: assert property (p_gate_follow)
		else $error("channel 1 gate ignores its command");

	property p_enable_off;
		@(posedge clk) disable iff (rst)
		!output_enable |=> gate_drive_output == 4'h0;
	endproperty
	a_enable_off: assert property (p_enable_off)
		else $error("gate on while output enable low");

	property p_pin_clear;
		@(posedge clk) disable iff (rst)
		(!reset_sleep_n && drain_sense_input == 4'h0 &&
			source_sense_input == 4'h0 && open_load_sense == 4'h0)
			|=> (has == 4'h0 && input_q == 8'h00);
	endproperty
	a_pin_clear: assert property (p_pin_clear)
		else $error("reset pin low left faults latched");

	property p_sleep_entry;
		@(posedge clk) disable iff (rst)
		(!reset_sleep_n && low_cnt_q == SLEEP_LIM) |=> sleep_q;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry)
		else $error("no sleep after hold time");

	property p_sleep_off;
		@(posedge clk) disable iff (rst)
		sleep_q |-> (!pump_en && !regulator_en && sys_q == '0 &&
			cfg_q == '0);
	endproperty
	a_sleep_off: assert property (p_sleep_off)
		else $error("circuits or registers alive in sleep");

	property p_fault_pin;
		@(posedge clk) disable iff (rst)
		(reset_sleep_n && (|sys_raw || |has)) |=> fault_flag_n_oe;
	endproperty
	a_fault_pin: assert property (p_fault_pin)
		else $error("fault pin not asserted");

	property p_sys_hold;
		@(posedge clk) disable iff (rst)
		(sys_q.thermal && !fault_rd && reset_sleep_n) |=> sys_q.thermal;
	endproperty
	a_sys_hold: assert property (p_sys_hold)
		else $error("thermal flag dropped before read");

	property p_power_zero;
		@(posedge clk) rst |=> (sys_q == '0 && rdata == 8'h00);
	endproperty
	a_power_zero: assert property (p_power_zero)
		else $error("fault register not zero after power up");

	property p_ch_select;
		@(posedge clk) disable iff (rst)
		(cmd_wr && wdata[7:5] == 3'b101) |=>
			cfg_q[2].gate == $past(wdata[0]);
	endproperty
	a_ch_select: assert property (p_ch_select)
		else $error("address 10 did not reach channel 3");

	c_sleep: cover property (@(posedge clk) disable iff (rst)
		$rose(sleep_q));
	c_multi: cover property (@(posedge clk) disable iff (rst)
		fault_rd && has[1] && has[3]);
	c_sys_read: cover property (@(posedge clk) disable iff (rst)
		fault_rd && sys_q.pump_uv);
endmodule // gate_drv_ctrl
`default_nettype wire

// >>> include/gate_drv_pkg.sv
// shared constants and types of the four-channel gate driver control
`default_nettype none
package gate_drv_pkg;
	// ==========================================================
	// sizes and timing
	localparam int NUM_CH = 4;
	localparam int CLK_PERIOD_NS = 8;
	localparam int BLANK_W = 12;
	// least times, rounded up to whole cycles
	localparam int TON0_NS = 4000;
	localparam int TON1_NS = 8000;
	localparam int TON2_NS = 16000;
	localparam int TON3_NS = 32000;
	localparam int TOFF_NS = 8000;
	localparam int SLEEP_HOLD_NS = 100000;
	localparam int TON0_CYC = (TON0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TON1_CYC = (TON1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TON2_CYC = (TON2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TON3_CYC = (TON3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TOFF_CYC = (TOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLEEP_CYC =
		(SLEEP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// register map and fields
	localparam logic [7:0] CMD_ADDR = 8'h00;
	localparam logic [7:0] FAULT_ADDR = 8'h04;
	localparam logic [7:0] STAT_ADDR = 8'h08;
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [2:0] SYS_RESET = 3'h0;
	localparam int CMD_GATE_BIT = 0;
	localparam int CMD_BLANK_LSB = 1;
	localparam int CMD_CLEAR_BIT = 3;
	localparam int CMD_MASK_BIT = 4;
	localparam int CMD_RDEN_BIT = 5;
	localparam int CMD_CH_LSB = 6;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic mask;
		logic [1:0] blank;
		logic gate;
	} ch_cfg_t;

	// bit order matches fault byte bits 2..0
	typedef struct packed {
		logic ol;
		logic stb;
		logic stg;
	} load_flt_t;

	// bit order matches fault byte bits 5..3
	typedef struct packed {
		logic supply_uv;
		logic pump_uv;
		logic thermal;
	} sys_flt_t;

	typedef struct packed {
		logic drain;
		logic source;
		logic open_load;
	} sense_t;

	// turn-on blank select to cycle count
	function automatic logic [BLANK_W-1:0] blank_cycles(
		input logic [1:0] sel);
		case (sel)
			2'h0: blank_cycles = BLANK_W'(TON0_CYC);
			2'h1: blank_cycles = BLANK_W'(TON1_CYC);
			2'h2: blank_cycles = BLANK_W'(TON2_CYC);
			default: blank_cycles = BLANK_W'(TON3_CYC);
		endcase
	endfunction
endpackage
`default_nettype wire

// >>> hw/gate_channel.sv
// one output channel: gate decision, blank timers, latched load faults
`default_nettype none
module gate_channel (
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_on,
	input wire logic drive_ok,
	input wire logic clear,
	input wire logic sleep,
	input wire gate_drv_pkg::sense_t sense,
	input wire gate_drv_pkg::ch_cfg_t cfg,
	output logic gate_q,
	output gate_drv_pkg::load_flt_t flt_q
);
	// ==========================================================
	// gate and fault state
	logic gate_d;
	logic [gate_drv_pkg::BLANK_W-1:0] cnt_q, cnt_d, lim;
	logic armed;
	gate_drv_pkg::load_flt_t flt_d, set;

	always_comb begin
		// off-state faults hold the gate off unless masked
		gate_d = cmd_on && drive_ok && !flt_q.stg && !sleep &&
			!(!cfg.mask && (flt_q.stb || flt_q.ol));
		lim = gate_q ? gate_drv_pkg::blank_cycles(cfg.blank) :
			gate_drv_pkg::BLANK_W'(gate_drv_pkg::TOFF_CYC);
		armed = (cnt_q == lim);
		if (gate_q != gate_d) begin
			cnt_d = '0;
		end else if (!armed) begin
			cnt_d = cnt_q + 1'b1;
		end else begin
			cnt_d = cnt_q;
		end
		set.stg = gate_q && armed && sense.drain;
		set.stb = !gate_q && armed && sense.source && !cfg.mask;
		set.ol = !gate_q && armed && sense.open_load && !cfg.mask;
		// detection wins over a clear in the same cycle
		flt_d = (clear || sleep) ? set : (flt_q | set);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			gate_q <= 1'b0;
			cnt_q <= '0;
			flt_q <= '0;
		end else begin
			gate_q <= gate_d;
			cnt_q <= cnt_d;
			flt_q <= flt_d;
		end
	end

	// ==========================================================
	// checks
	property p_stg_off;
		@(posedge clk) disable iff (rst)
		flt_q.stg |=> !gate_q;
	endproperty
	a_stg_off: assert property (p_stg_off)
		else $error("gate stays on with a latched short to ground");
	c_stg_latch: cover property (@(posedge clk) disable iff (rst)
		$rose(flt_q.stg));
endmodule // gate_channel
`default_nettype wire

// >>> verification/host_model.sv
// host microcontroller model driving discrete pins and the reset pin
`default_nettype none
module host_model (
	input wire logic clk,
	input wire logic [3:0] gate_req,
	input wire logic en_req,
	input wire logic pulse_req,
	input wire logic hold_req,
	output logic [3:0] gate_command_input,
	output logic output_enable,
	output logic reset_sleep_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// pin registers
	// pins move only right after an edge, like firmware port writes
	logic [3:0] gate_q = 4'h0;
	logic en_q = 1'h1;
	logic rsn_q = 1'h1;
	logic low_q = 1'h0;
	always @(posedge clk) begin
		gate_q <= gate_req;
		en_q <= en_req;
		low_q <= pulse_req;
		// pulse is two cycles low; hold keeps it low for sleep
		rsn_q <= !(hold_req || pulse_req || low_q);
	end
	assign gate_command_input = gate_q;
	assign output_enable = en_q;
	assign reset_sleep_n = rsn_q;
endmodule // host_model
`default_nettype wire

// >>> verification/gate_drv_ctrl_tb.sv
// self-checking bench of the gate driver control block
`default_nettype none
module gate_drv_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// stimulus and wiring
	localparam int SLP = 20;
	localparam logic [7:0] SYSX [4] = '{8'h08, 8'h20, 8'h10, 8'h20};
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rd_val;
	logic wr_en = 1'h0, rd_en = 1'h0;
	logic [3:0] gate_req = 4'h0, drain = 4'h0, src = 4'h0, ol = 4'h0;
	logic [3:0] sysf = 4'h0, gates, gin;
	logic en_req = 1'h1, pulse_req = 1'h0, hold_req = 1'h0;
	logic oe_pin, rsn, fo, foe, pump_en, reg_en, sleep;
	wire fault_wire;
	int n_mismatch = 0;
	int samples_checked = 0;
	// open-drain wire with pull-up
	assign fault_wire = foe ? fo : 1'h1;
	always #4 clk = ~clk;
	host_model i_host (.clk(clk), .gate_req(gate_req), .en_req(en_req),
		.pulse_req(pulse_req), .hold_req(hold_req),
		.gate_command_input(gin), .output_enable(oe_pin),
		.reset_sleep_n(rsn));
	gate_drv_ctrl #(.SLEEP_CYCLES(SLP)) i_dut (.clk(clk), .rst(rst),
		.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .gate_command_input(gin),
		.drain_sense_input(drain), .source_sense_input(src),
		.open_load_sense(ol), .output_enable(oe_pin),
		.reset_sleep_n(rsn), .regulator_uv(sysf[3]), .pump_uv(sysf[2]),
		.logic_uv(sysf[1]), .thermal_warn(sysf[0]),
		.gate_drive_output(gates), .fault_flag_n_i(fault_wire),
		.fault_flag_n_o(fo), .fault_flag_n_oe(foe), .pump_en(pump_en),
		.regulator_en(reg_en), .sleep_mode(sleep));
	// ==========================================================
	// tasks
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		rd_en <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'h0;
		#1;
		rd_val = rdata;
	endtask
	task automatic pulse;
		@(posedge clk);
		pulse_req <= 1'h1;
		@(posedge clk);
		pulse_req <= 1'h0;
		cyc(5);
	endtask
	task automatic gchk(input logic [3:0] exp);
		cyc(3);
		chk("gates", {4'h0, exp}, {4'h0, gates});
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ==========================================================
	// watchdog: whole run needs well under 5000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		$display("MISMATCH watchdog expected finish seen timeout");
		complete_run();
	end
	// ==========================================================
	// test sequence
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		cyc(2);
		rd(8'h04);
		chk("power-up fault", 8'h00, rd_val);
		pulse();
		for (int c = 0; c < 4; c++) begin
			@(posedge clk);
			gate_req <= 4'h1 << c;
			gchk(4'h1 << c);
		end
		@(posedge clk);
		gate_req <= 4'h0;
		gchk(4'h0);
		// serial gate bit per channel, address bits pick the channel
		for (int c = 0; c < 4; c++) begin
			wr(8'h00, {c[1:0], 6'h21});
			gchk(4'((5'h2 << c) - 5'h1));
		end
		// read enable low: byte is kept for readback but acts on nothing
		wr(8'h00, 8'h1E);
		gchk(4'hF);
		rd(8'h00);
		chk("input reg", 8'h1E, rd_val);
		@(posedge clk);
		en_req <= 1'h0;
		gchk(4'h0);
		@(posedge clk);
		en_req <= 1'h1;
		gchk(4'hF);
		pulse();
		gchk(4'h0);
		rd(8'h00);
		chk("input reg", 8'h00, rd_val);
		@(posedge clk);
		gate_req <= 4'h1;
		// system causes: thermal, logic, pump, regulator
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			sysf <= 4'h1 << i;
			cyc(3);
			rd(8'h08);
			chk("status", (i == 0) ? 8'h01 : 8'h00, rd_val);
			@(posedge clk);
			sysf <= 4'h0;
			cyc(3);
			rd(8'h04);
			chk("sys flag", SYSX[i], rd_val);
			rd(8'h04);
			chk("sys flag", 8'h00, rd_val);
		end
		rd(8'h08);
		chk("status", 8'h81, rd_val);
		// short to ground on channels 1 and 3, channel 3 on the longer blank
		wr(8'h00, 8'hA2);
		@(posedge clk);
		gate_req <= 4'h5;
		drain <= 4'h5;
		cyc(gate_drv_pkg::TON0_CYC + 10);
		chk("gates", 8'h04, {4'h0, gates});
		cyc(gate_drv_pkg::TON1_CYC - gate_drv_pkg::TON0_CYC);
		chk("gates", 8'h00, {4'h0, gates});
		rd(8'h08);
		chk("status", 8'h00, rd_val);
		@(posedge clk);
		drain <= 4'h0;
		wr(8'h00, 8'hA8);
		gchk(4'h4);
		rd(8'h04);
		chk("load fault", 8'h01, rd_val);
		pulse();
		gchk(4'h5);
		// off-state faults on channel 4, open load on channel 2
		@(posedge clk);
		src <= 4'h8;
		ol <= 4'hA;
		cyc(gate_drv_pkg::TOFF_CYC + 10);
		rd(8'h04);
		chk("load fault", 8'h44, rd_val);
		rd(8'h04);
		chk("load fault", 8'hC6, rd_val);
		rd(8'h04);
		chk("load fault", 8'h44, rd_val);
		@(posedge clk);
		gate_req <= 4'hD;
		gchk(4'h5);
		wr(8'h00, 8'hF0);
		gchk(4'hD);
		@(posedge clk);
		src <= 4'h0;
		ol <= 4'h0;
		hold_req <= 1'h1;
		cyc(SLP - 2);
		chk("sleep", 8'h06, {4'h0, sleep, pump_en, reg_en, 1'h0});
		cyc(8);
		chk("sleep", 8'h08, {4'h0, sleep, pump_en, reg_en, foe});
		@(posedge clk);
		hold_req <= 1'h0;
		cyc(6);
		chk("wake", 8'h01, {6'h00, sleep, pump_en});
		rd(8'h04);
		chk("fault reg", 8'h00, rd_val);
		rd(8'h00);
		chk("input reg", 8'h00, rd_val);
		pulse();
		complete_run();
	end
endmodule // gate_drv_ctrl_tb
`default_nettype wire
